// ---- rtl/srh_pkg.sv ----
// Constants for the asynchronous static RAM host controller.
// Assumes a single 50 MHz clock; all figures below are for the slow speed grade.
// Functional notes
// RULE1: During every read the controller holds the write strobe high so the memory returns data.
// RULE2: Address-driven reads may keep select and output drive low and only change the address.
// RULE3: For reads started by select, the address is valid no later than the falling select edge.
// RULE4: The memory writes only while select and write strobe are both low.
// RULE5: A write starts with all controls valid and ends when select or write strobe rises.
// RULE6: Data setup and hold are measured from whichever edge ends the write.
// RULE7: Write data is stable at least 20 ns before the ending edge, no hold needed after it.
// RULE8: The address is valid at least 25 ns before the ending edge.
// RULE9: The address may change right at the ending edge; its hold time is zero.
// RULE10: After the write strobe falls the memory floats its data pins within 20 ns.
// RULE11: After the write strobe rises the memory may drive again at once, so the host lets go first; the code drops mem_data_oe on that same edge.
// RULE12: With output drive high during a write the memory keeps its data pins floating.
// RULE13: Before low-supply retention the host deasserts select, with a least lead time of 0 ns.
// RULE14: The memory holds 32768 bytes behind a 15-bit address and one shared 8-bit data bus.
package srh_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned ADDR_W = 15; // 32768 words
  localparam int unsigned DATA_W = 8;
  // Write timing, slow grade
  localparam int unsigned WRITE_DATA_SETUP_NS = 20;
  localparam int unsigned ADDR_SETUP_TO_END_NS = 25;
  localparam int unsigned STROBE_WIDTH_NS = 25;
  localparam int unsigned SELECT_TO_END_NS = 35;
  localparam int unsigned WRITE_CYCLE_NS = 45;
  localparam int unsigned STROBE_LOW_TO_FLOAT_DELAY_NS = 20;
  localparam int unsigned WRITE_ADDRESS_HOLD_NS = 0;
  // Read timing, slow grade
  localparam int unsigned READ_ACCESS_NS = 45;
  localparam int unsigned READ_CYCLE_NS = 45;
  function automatic int unsigned ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c == 0) ? 1 : c;
  endfunction
  // Strobe low time covers address-to-end, width, select-to-end and data setup
  localparam int unsigned WR_LOW_CYC = ns_to_cyc(SELECT_TO_END_NS);
  localparam int unsigned RD_WAIT_CYC = ns_to_cyc(READ_ACCESS_NS) + 1;
  localparam int unsigned FLOAT_CYC = ns_to_cyc(STROBE_LOW_TO_FLOAT_DELAY_NS);
  localparam int unsigned CNT_W = 4;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 15'h0000;
endpackage

// ---- rtl/srh_cycle_timer.sv ----
`timescale 1ns/1ps
// Down counter that times the phases of one memory cycle.
// Assumes a synchronous load pulse from the controller's sequencer.
module srh_cycle_timer
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic load,
  input wire logic [srh_pkg::CNT_W-1:0] load_val,
  output logic done
);
  logic [srh_pkg::CNT_W-1:0] cnt_r;

  // Load wins; otherwise count down and rest at zero
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      cnt_r <= 4'h0;
    else if (clk_en)
    begin
      if (load)
        cnt_r <= load_val;
      else if (cnt_r != 4'h0)
        cnt_r <= cnt_r - 4'h1;
    end
  end

  assign done = (cnt_r == 4'h0);
endmodule // srh_cycle_timer

// ---- rtl/srh_host.sv ----
`timescale 1ns/1ps
// Host controller that drives an asynchronous static RAM through its pins.
// Assumes the memory pins are sampled and driven synchronously to clk; the bench
// resolves the shared data wire from mem_data_oe.
module srh_host
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // User side
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [srh_pkg::ADDR_W-1:0] req_addr,
  input wire logic [srh_pkg::DATA_W-1:0] req_wdata,
  input wire logic retain_req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [srh_pkg::DATA_W-1:0] rsp_rdata,
  output logic retain_ok,
  // Memory side
  output logic [srh_pkg::ADDR_W-1:0] mem_addr,
  output logic mem_select_n,
  output logic mem_write_n,
  output logic mem_drive_n,
  input wire logic [srh_pkg::DATA_W-1:0] mem_data_in,
  output logic [srh_pkg::DATA_W-1:0] mem_data_out,
  output logic mem_data_oe
);
  typedef enum logic [5:0] {
    ST_IDLE   = 6'b000001,
    ST_RSETUP = 6'b000010,
    ST_RWAIT  = 6'b000100,
    ST_WSETUP = 6'b001000,
    ST_WLOW   = 6'b010000,
    ST_WEND   = 6'b100000
  } srh_state_e;

  srh_state_e state_r;
  srh_state_e state_nxt;
  logic tmr_load;
  logic [srh_pkg::CNT_W-1:0] tmr_val;
  logic tmr_done;

  // A request is taken only while ready is shown, so the handshake and the
  // sequencer agree on which edge accepted it, except when retain_req is high on that edge. The cost is one
  // extra idle cycle after retention is released, before ready comes back.
  function automatic logic take_now(input srh_state_e st, input logic valid, input logic ready,
    input logic retain);
    return (st == ST_IDLE) && valid && ready && !retain;
  endfunction

  srh_cycle_timer u_timer
  (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .load(tmr_load),
    .load_val(tmr_val),
    .done(tmr_done)
  );

  // Next state and timer loads
  always_comb
  begin
    state_nxt = state_r;
    tmr_load = 1'b0;
    tmr_val = '0;
    unique case (state_r)
      ST_IDLE:
        if (take_now(state_r, req_valid, req_ready, retain_req))
        begin
          state_nxt = req_write ? ST_WSETUP : ST_RSETUP;
        end
      ST_RSETUP:
      begin
        // Address is already stable one cycle before select falls
        state_nxt = ST_RWAIT; // see RULE3
        tmr_load = 1'b1;
        tmr_val = srh_pkg::CNT_W'(srh_pkg::RD_WAIT_CYC);
      end
      ST_RWAIT:
        if (tmr_done)
          state_nxt = ST_IDLE;
      ST_WSETUP:
      begin
        state_nxt = ST_WLOW;
        tmr_load = 1'b1;
        tmr_val = srh_pkg::CNT_W'(srh_pkg::WR_LOW_CYC);
      end
      ST_WLOW:
        if (tmr_done)
          state_nxt = ST_WEND;
      ST_WEND:
        state_nxt = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      state_r <= ST_IDLE;
    else if (clk_en)
      state_r <= state_nxt;
  end

  // Control strobes; select and strobe fall together once address and data are set up
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mem_select_n <= 1'b1;
      mem_write_n <= 1'b1;
      mem_drive_n <= 1'b1;
    end
    else if (clk_en)
    begin
      mem_select_n <= !(state_nxt == ST_RWAIT || state_nxt == ST_WLOW); // see RULE5
      mem_write_n <= !(state_nxt == ST_WLOW); // see RULE1, RULE4
      // Output drive stays high through writes so the memory never fights our data.
      // Every read is started by select; holding select low across reads is legal
      // but not used, so each read gets the same select-to-data wait.
      mem_drive_n <= !(state_nxt == ST_RWAIT); // see RULE12, RULE2
    end
  end

  // Address and write data; both ride from setup through the rising edges
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mem_addr <= srh_pkg::ADDR_RESET;
      mem_data_out <= srh_pkg::DATA_RESET;
    end
    else if (clk_en && take_now(state_r, req_valid, req_ready, retain_req))
    begin
      mem_addr <= req_addr; // see RULE8, RULE9
      mem_data_out <= req_wdata; // see RULE7
    end
  end

  // Data drive: on during setup and low time, off on the same edge both strobes rise.
  // Releasing at the ending edge is safe because hold is zero and the memory
  // keeps its pins floating with output drive high.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      mem_data_oe <= 1'b0;
    else if (clk_en)
      mem_data_oe <= (state_nxt == ST_WSETUP || state_nxt == ST_WLOW); // see RULE6, RULE11
  end

  // Capture read data at the end of the access wait
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rsp_valid <= 1'b0;
      rsp_rdata <= srh_pkg::DATA_RESET;
    end
    else if (clk_en)
    begin
      rsp_valid <= 1'b0;
      if (state_r == ST_RWAIT && tmr_done)
      begin
        rsp_valid <= 1'b1;
        rsp_rdata <= mem_data_in; // see RULE14
      end
    end
  end

  // Ready and retention handshake; select is already high whenever we idle
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      req_ready <= 1'b0;
      retain_ok <= 1'b0;
    end
    else if (clk_en)
    begin
      req_ready <= (state_nxt == ST_IDLE) && !retain_req;
      retain_ok <= (state_nxt == ST_IDLE) && retain_req; // see RULE13
    end
  end
endmodule // srh_host

// ---- testbench/srh_properties.sv ----
// Checker for the static RAM host pins.
// Assumes it is bound to srh_host.
`timescale 1ns/1ps
module srh_properties
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic retain_ok,
  input wire logic [srh_pkg::ADDR_W-1:0] mem_addr,
  input wire logic mem_select_n,
  input wire logic mem_write_n,
  input wire logic mem_drive_n,
  input wire logic [srh_pkg::DATA_W-1:0] mem_data_out,
  input wire logic mem_data_oe
);
  // All checks share one clock and reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_rd_we; !mem_drive_n |-> mem_write_n; endproperty
  a_rd_we: assert property (p_rd_we) else $error("strobe low in read");
  property p_rd_lat; clk_en && req_valid && req_ready && !req_write |-> ##7 rsp_valid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_addr; !mem_select_n |-> $stable(mem_addr); endproperty
  a_addr: assert property (p_addr) else $error("address moved");
  property p_wr_len; $fell(mem_write_n) |-> !mem_write_n [*2] ##[1:2] mem_write_n; endproperty
  a_wr_len: assert property (p_wr_len) else $error("strobe width");
  property p_wr_end; $rose(mem_write_n) |-> $rose(mem_select_n); endproperty
  a_wr_end: assert property (p_wr_end) else $error("write end split");
  property p_wdata; !mem_write_n |-> mem_data_oe && $stable(mem_data_out); endproperty
  a_wdata: assert property (p_wdata) else $error("write data moved");
  property p_rel; $rose(mem_write_n) |-> !mem_data_oe && mem_drive_n; endproperty
  a_rel: assert property (p_rel) else $error("bus not released");
  property p_ret; retain_ok |-> mem_select_n; endproperty
  a_ret: assert property (p_ret) else $error("selected in retention");
endmodule // srh_properties
bind srh_host srh_properties i_srh_properties (.clk, .reset_n, .clk_en, .req_valid, .req_write, .req_ready,
  .rsp_valid, .retain_ok, .mem_addr, .mem_select_n, .mem_write_n, .mem_drive_n, .mem_data_out, .mem_data_oe);

// ---- testbench/srh_sram_model.sv ----
// Behavioural model of the byte-wide static RAM.
// Assumes the bench resolves the shared data wire.
`timescale 1ns/1ps
module srh_sram_model
(
  input wire logic [srh_pkg::ADDR_W-1:0] addr,
  input wire logic select_n,
  input wire logic write_n,
  input wire logic drive_n,
  input wire logic [srh_pkg::DATA_W-1:0] din,
  output logic [srh_pkg::DATA_W-1:0] q,
  output logic q_en
);
  logic [srh_pkg::DATA_W-1:0] mem [0:32767];
  logic wr_act;
  // Store at whichever edge ends the overlap
  assign wr_act = !select_n && !write_n;
  always @(negedge wr_act)
  begin
    mem[addr] = din;
  end
  // Floating pins show inverted data so stale values never pass
  assign q_en = !select_n && !drive_n && write_n;
  assign q = q_en ? mem[addr] : ~mem[addr];
endmodule // srh_sram_model

// ---- testbench/tb_top.sv ----
// Self-checking bench for the static RAM host.
// Assumes package and design compiled first.
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [14:0] req_addr = 15'h0000;
  logic [7:0] req_wdata = 8'h00;
  logic retain_req = 1'b0;
  logic req_ready, rsp_valid, retain_ok, mem_select_n, mem_write_n, mem_drive_n, mem_data_oe, q_en;
  logic [14:0] mem_addr;
  logic [7:0] rsp_rdata, mem_data_out, q;
  wire logic [7:0] data_w;
  int failures = 0;
  int n_tests = 0;
  always #10 clk = ~clk;
  // Wire delay keeps zero-hold data valid at the write end
  assign #1 data_w = (mem_data_oe && q_en) ? 8'hxx : mem_data_oe ? mem_data_out : q;
  srh_host i_srh_host (.clk, .reset_n, .clk_en, .req_valid, .req_write, .req_addr, .req_wdata,
    .retain_req, .req_ready, .rsp_valid, .rsp_rdata, .retain_ok, .mem_addr, .mem_select_n,
    .mem_write_n, .mem_drive_n, .mem_data_in(data_w), .mem_data_out, .mem_data_oe);
  srh_sram_model i_srh_sram_model (.addr(mem_addr), .select_n(mem_select_n), .write_n(mem_write_n),
    .drive_n(mem_drive_n), .din(data_w), .q, .q_en);
  task automatic chk(input bit ok);
    n_tests++;
    if (!ok)
    begin
      failures++;
      $display("Error at %0t: mismatch", $time);
    end
  endtask
  task automatic req(input logic w, input logic [14:0] a, input logic [7:0] d);
    int n;
    @(negedge clk);
    {req_valid, req_write, req_addr, req_wdata} = {1'b1, w, a, d};
    for (n = 0; n < 50 && req_ready !== 1'b1; n++) @(negedge clk);
    chk(req_ready === 1'b1);
    @(negedge clk);
    req_valid = 1'b0;
  endtask
  task automatic rd(input logic [14:0] a, input logic [7:0] e);
    int n;
    req(1'b0, a, 8'h00);
    for (n = 0; n < 20 && rsp_valid !== 1'b1; n++) @(negedge clk);
    chk(rsp_valid === 1'b1 && rsp_rdata === e);
  endtask
  task automatic t_edges;
    req(1'b1, 15'h0000, 8'h5a);
    req(1'b1, 15'h7fff, 8'ha5);
    rd(15'h0000, 8'h5a);
    rd(15'h7fff, 8'ha5);
    $display("edges done");
  endtask
  task automatic t_burst;
    for (int i = 0; i < 4; i++) req(1'b1, 15'h1234 + 15'(i), 8'h30 + 8'(i));
    for (int i = 0; i < 4; i++) rd(15'h1234 + 15'(i), 8'h30 + 8'(i));
    $display("burst done");
  endtask
  // Enable low must freeze the idle controller, then the held read goes through
  task automatic t_freeze;
    @(negedge clk);
    clk_en = 1'b0;
    {req_valid, req_write, req_addr} = {1'b1, 1'b0, 15'h0000};
    repeat (4) @(negedge clk);
    chk(mem_select_n === 1'b1 && rsp_valid === 1'b0 && req_ready === 1'b1);
    clk_en = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    for (int n = 0; n < 20 && rsp_valid !== 1'b1; n++) @(negedge clk);
    chk(rsp_valid === 1'b1 && rsp_rdata === 8'h5a);
    $display("freeze done");
  endtask
  task automatic t_retain;
    @(negedge clk);
    retain_req = 1'b1;
    repeat (10) @(negedge clk);
    chk(retain_ok === 1'b1 && mem_select_n === 1'b1 && req_ready === 1'b0);
    retain_req = 1'b0;
    rd(15'h7fff, 8'ha5);
    $display("retain done");
  endtask
  task print_verdict;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    t_edges();
    t_burst();
    t_freeze();
    t_retain();
    print_verdict();
  end
  // Watchdog well past the expected run
  initial
  begin
    #100000;
    failures++;
    print_verdict();
  end
endmodule // tb_top
